// file: rtl/segdrv_defs.svh
// constants and operation summary for the seven-segment shift-out driver
// Operation
// - Display data leaves one bit at a time on the serial display output into the first register of the chain.
// - A shift clock common to all chained registers advances the serial data by one bit per pulse.
// - A latch clock pulse copies every register's shifted contents into its parallel output buffer.
// - An output enable switches the register outputs on and off and is modulated to set brightness.
// - A chain clear output empties the shift stages of every register when wired to all of them; output buffers keep their contents.
// - The stream is ordered so the register next to the serial output holds the units digit.
// - In each digit byte bit 0 drives decimal point and colon, bits 1 to 7 drive segments A to G.
// - All timing derives from the 8 MHz clock of the device.
// - Three separate button inputs are sampled as the keyboard.
// - The buzzer is sounded by sinking current on the buzzer output.
// - In normal operation the display alternates between temperature and time or date.
// - While the menu is shown the output enable is held at full brightness.
// - The display is static: patterns stay latched, never multiplexed in time.
`ifndef SEGDRV_DEFS_SVH
`define SEGDRV_DEFS_SVH
`define SEG_CLK_HZ 8000000
`define SEG_SHIFT_DIV 8
`define SEG_DP_BIT 0
`define SEG_A_BIT 1
`define SEG_ALT_CYCLES 16000000
`define SEG_PWM_STEPS 256
`define SEG_CLEAR_CYCLES 4
`endif

// file: rtl/segdrv_pkg.sv
// types for the seven-segment shift-out driver
package segdrv_pkg;
    typedef enum logic [2:0] {ST_CLEAR, ST_IDLE, ST_LOAD, ST_LOW, ST_HIGH, ST_LATCH} shift_state_t;
endpackage : segdrv_pkg

// file: rtl/seven_segment_shift_out_driver.sv
// static seven-segment shift-out driver with frame fifo and brightness pwm
`timescale 1ns/1ps
`include "segdrv_defs.svh"

module segdrv_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_wr, do_rd;
    assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_q != '0);
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;
    assign rd_data_out = mem_q[rp_q];
    always_comb begin
        wp_d = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d = do_rd ? rp_q + 1'b1 : rp_q;
        cnt_d = cnt_q + {{AW{1'b0}}, do_wr} - {{AW{1'b0}}, do_rd};
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
        if (do_wr) begin
            mem_q[wp_q] <= wr_data_in;
        end
    end
endmodule : segdrv_fifo

module seven_segment_shift_out_driver
    import segdrv_pkg::*;
#(
    parameter int DIGITS = 4,
    parameter int DEPTH = 16,
    parameter int ALT_CYCLES = `SEG_ALT_CYCLES
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [8*DIGITS-1:0] temp_frame_in,
    input wire logic [8*DIGITS-1:0] time_frame_in,
    input wire logic [8*DIGITS-1:0] menu_frame_in,
    input wire logic menu_active_in,
    input wire logic [7:0] brightness_in,
    input wire logic alarm_in,
    input wire logic button_one_in,
    input wire logic button_two_in,
    input wire logic button_three_in,
    output logic serial_display_out,
    output logic shift_clock_out,
    output logic latch_clock_out,
    output logic output_enable_n_out,
    output logic chain_clear_out,
    output logic buzzer_sink_n_out,
    output logic [2:0] button_pressed_out,
    output logic frame_ready_out
);
    localparam int FW = 8 * DIGITS;
    localparam int BW = $clog2(FW + 1);
    localparam int DW = $clog2(`SEG_SHIFT_DIV); // all timing counted in mclk_in cycles

    // button sync: 3 flops, change counts when stages 2 and 3 agree
    logic [2:0] btn_raw;
    logic [2:0] s1_q, s2_q, s3_q, pr_q, pr_d;
    assign btn_raw = {button_three_in, button_two_in, button_one_in};
    always_comb begin
        pr_d = pr_q;
        for (int i = 0; i < 3; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                pr_d[i] = ~s3_q[i]; // low level means pressed
            end
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s1_q <= 3'h7;
            s2_q <= 3'h7;
            s3_q <= 3'h7;
            pr_q <= 3'h0;
        end else begin
            s1_q <= btn_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            pr_q <= pr_d;
        end
    end
    assign button_pressed_out = pr_q;

    // buzzer sinks current when alarm is on
    logic buz_q, buz_d;
    always_comb begin
        buz_d = ~alarm_in;
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            buz_q <= 1'b1;
        end else begin
            buz_q <= buz_d;
        end
    end
    assign buzzer_sink_n_out = buz_q;

    // alternation timer picks temperature or time frame
    logic [31:0] alt_q, alt_d;
    logic show_time_q, show_time_d, alt_tick;
    assign alt_tick = (alt_q == 32'(ALT_CYCLES - 1));
    always_comb begin
        alt_d = alt_tick ? 32'h0 : alt_q + 32'h1;
        show_time_d = alt_tick ? ~show_time_q : show_time_q;
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            alt_q <= 32'h0;
            show_time_q <= 1'b0;
        end else begin
            alt_q <= alt_d;
            show_time_q <= show_time_d;
        end
    end

    // frame source: a new frame is queued when the chosen content differs from the last queued frame and no push is pending
    logic [FW-1:0] src_frame, last_q, last_d;
    logic push_q, push_d, wr_ready;
    logic [FW-1:0] rd_data;
    logic rd_valid, rd_ready;
    assign src_frame = menu_active_in ? menu_frame_in : (show_time_q ? time_frame_in : temp_frame_in);
    always_comb begin
        last_d = last_q;
        push_d = push_q;
        if (push_q && wr_ready) begin
            push_d = 1'b0;
        end
        if (src_frame != last_q && !push_q) begin
            last_d = src_frame;
            push_d = 1'b1;
        end
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            last_q <= '0;
            push_q <= 1'b1;
        end else begin
            last_q <= last_d;
            push_q <= push_d;
        end
    end
    assign frame_ready_out = wr_ready;

    segdrv_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .wr_data_in(last_q),
        .wr_valid_in(push_q),
        .wr_ready_out(wr_ready),
        .rd_data_out(rd_data),
        .rd_valid_out(rd_valid),
        .rd_ready_in(rd_ready)
    );

    // shift engine: msb of the most distant digit first, units digit last
    shift_state_t st_q, st_d;
    logic [FW-1:0] sh_q, sh_d;
    logic [BW-1:0] bits_q, bits_d;
    logic [DW-1:0] div_q, div_d;
    logic sdo_q, sdo_d, sck_q, sck_d, lat_q, lat_d, clr_q, clr_d;
    logic div_end;
    assign div_end = (div_q == DW'(`SEG_SHIFT_DIV / 2 - 1));
    assign rd_ready = (st_q == ST_IDLE);
    always_comb begin
        st_d = st_q;
        sh_d = sh_q;
        bits_d = bits_q;
        div_d = div_end ? '0 : div_q + 1'b1;
        sdo_d = sdo_q;
        sck_d = 1'b0;
        lat_d = 1'b0;
        clr_d = 1'b0;
        unique case (st_q)
            ST_CLEAR: begin
                clr_d = 1'b1; // chain cleared after reset
                if (div_end) begin
                    st_d = ST_IDLE;
                end
            end
            ST_IDLE: begin
                div_d = '0;
                if (rd_valid) begin
                    sh_d = rd_data;
                    bits_d = BW'(FW);
                    st_d = ST_LOAD;
                end
            end
            ST_LOAD: begin
                sdo_d = sh_q[FW-1]; // one bit at a time
                sh_d = {sh_q[FW-2:0], 1'b0};
                div_d = '0;
                st_d = ST_LOW;
            end
            ST_LOW: begin
                if (div_end) begin
                    st_d = ST_HIGH;
                end
            end
            ST_HIGH: begin
                sck_d = 1'b1; // one rising edge per bit
                if (div_end) begin
                    bits_d = bits_q - 1'b1;
                    st_d = (bits_q == BW'(1)) ? ST_LATCH : ST_LOAD;
                end
            end
            ST_LATCH: begin
                lat_d = 1'b1; // only after a whole frame
                if (div_end) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            st_q <= ST_CLEAR;
            sh_q <= '0;
            bits_q <= '0;
            div_q <= '0;
            sdo_q <= 1'b0;
            sck_q <= 1'b0;
            lat_q <= 1'b0;
            clr_q <= 1'b1;
        end else begin
            st_q <= st_d;
            sh_q <= sh_d;
            bits_q <= bits_d;
            div_q <= div_d;
            sdo_q <= sdo_d;
            sck_q <= sck_d;
            lat_q <= lat_d;
            clr_q <= clr_d;
        end
    end
    assign serial_display_out = sdo_q;
    assign shift_clock_out = sck_q;
    assign latch_clock_out = lat_q; // static drive, latched until next frame
    assign chain_clear_out = clr_q;

    // brightness pwm on the active-low enable; menu forces full on
    logic [7:0] pwm_q, pwm_d;
    logic oe_n_q, oe_n_d;
    always_comb begin
        pwm_d = pwm_q + 8'h01;
        oe_n_d = menu_active_in ? 1'b0 : ~(pwm_q < brightness_in || brightness_in == 8'hFF);
    end
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            pwm_q <= 8'h00;
            oe_n_q <= 1'b1;
        end else begin
            pwm_q <= pwm_d;
            oe_n_q <= oe_n_d;
        end
    end
    assign output_enable_n_out = oe_n_q;

    // checks
    property p_menu_full;
        @(posedge mclk_in) disable iff (srst_in) menu_active_in |=> !output_enable_n_out;
    endproperty
    a_menu_full: assert property (p_menu_full) else $error("enable not full in menu");
    property p_latch_after_frame;
        @(posedge mclk_in) disable iff (srst_in) $rose(latch_clock_out) |-> $past(st_q, 2) == ST_HIGH && bits_q == '0;
    endproperty
    a_latch_after_frame: assert property (p_latch_after_frame) else $error("latch before frame end");
    property p_no_shift_latch;
        @(posedge mclk_in) disable iff (srst_in) !(shift_clock_out && latch_clock_out);
    endproperty
    a_no_shift_latch: assert property (p_no_shift_latch) else $error("shift and latch together");
    property p_data_stable;
        @(posedge mclk_in) disable iff (srst_in) shift_clock_out |-> $stable(serial_display_out);
    endproperty
    a_data_stable: assert property (p_data_stable) else $error("data moved during shift clock");
    property p_sck_width;
        @(posedge mclk_in) disable iff (srst_in) $rose(shift_clock_out) |-> shift_clock_out [*4] ##1 !shift_clock_out;
    endproperty
    a_sck_width: assert property (p_sck_width) else $error("shift clock width wrong");
    property p_btn_low;
        @(posedge mclk_in) disable iff (srst_in) (!button_one_in) [*5] |-> button_pressed_out[0];
    endproperty
    a_btn_low: assert property (p_btn_low) else $error("button low not seen pressed");
    property p_buzzer;
        @(posedge mclk_in) disable iff (srst_in) alarm_in |=> !buzzer_sink_n_out;
    endproperty
    a_buzzer: assert property (p_buzzer) else $error("buzzer not sinking");
    property p_dark;
        @(posedge mclk_in) disable iff (srst_in) (!menu_active_in && brightness_in == 8'h00) |=> output_enable_n_out;
    endproperty
    a_dark: assert property (p_dark) else $error("enable on at zero brightness");
endmodule : seven_segment_shift_out_driver

// file: tb/chain_model.sv
// behavioural chain of eight-bit serial-in parallel-out registers
`timescale 1ns/1ps

module chain_model #(
    parameter int DIGITS = 4
) (
    input wire logic mclk_in,
    input wire logic chain_serial_in,
    input wire logic sck_in,
    input wire logic rck_in,
    input wire logic oe_n_in,
    input wire logic clr_in,
    output logic [8*DIGITS-1:0] shift_q,
    output logic [8*DIGITS-1:0] latch_q,
    output logic [8*DIGITS-1:0] shown_out,
    output logic rck_rise_out,
    output int shifts_q
);
    logic sck_q = 1'b0;
    logic rck_q = 1'b0;
    initial shift_q = '0;
    initial latch_q = '0;
    initial shifts_q = 0;
    // edges found by sampling, as the far side sees a plain input
    assign rck_rise_out = rck_in & ~rck_q;
    // dark while the enable is released
    assign shown_out = oe_n_in ? '0 : latch_q;
    always @(posedge mclk_in) begin
        sck_q <= sck_in;
        rck_q <= rck_in;
        // clear empties shift stages only, storage keeps its picture
        if (clr_in) begin
            shift_q <= '0;
            shifts_q <= 0;
        end else if (rck_rise_out) begin
            latch_q <= shift_q;
            shifts_q <= 0;
        end else if (sck_in && !sck_q) begin
            // stage 0 of the nearest register takes the newest bit
            shift_q <= {shift_q[8*DIGITS-2:0], chain_serial_in};
            shifts_q <= shifts_q + 1;
        end
    end
endmodule : chain_model

// file: tb/tb.sv
// self-checking bench for the seven-segment shift-out driver
`timescale 1ns/1ps

module tb;
    typedef struct packed {logic [31:0] tf; logic [31:0] mf; logic ma; logic [31:0] exp;} row_t;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [31:0] temp_f = '0;
    logic [31:0] time_f = '0;
    logic [31:0] menu_f = '0;
    logic menu_a = 1'b0;
    logic [7:0] bright = 8'hFF;
    logic alarm = 1'b0;
    logic b1 = 1'b1;
    logic b2 = 1'b1;
    logic b3 = 1'b1;
    logic sdo, sck, rck, oe_n, clr, buzz_n, rdy, rck_rise;
    logic [2:0] pressed;
    logic [31:0] shift_q, latch_q, shown;
    int shifts;
    int n_mismatch = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;
    logic full;
    row_t rows [4] = '{
        '{32'h8142_2418, 32'h0, 1'b0, 32'h8142_2418},
        '{32'hFF00_01FE, 32'h0, 1'b0, 32'hFF00_01FE},
        '{32'h1234_5678, 32'hA5A5_0F0F, 1'b1, 32'hA5A5_0F0F},
        '{32'h0000_0001, 32'hFFFF_FFFF, 1'b0, 32'h0000_0001}};

    always #20 mclk_in = ~mclk_in;

    seven_segment_shift_out_driver #(.DIGITS(4), .DEPTH(16), .ALT_CYCLES(200)) dut (
        .mclk_in(mclk_in), .srst_in(srst_in), .temp_frame_in(temp_f), .time_frame_in(time_f),
        .menu_frame_in(menu_f), .menu_active_in(menu_a), .brightness_in(bright), .alarm_in(alarm),
        .button_one_in(b1), .button_two_in(b2), .button_three_in(b3), .serial_display_out(sdo),
        .shift_clock_out(sck), .latch_clock_out(rck), .output_enable_n_out(oe_n),
        .chain_clear_out(clr), .buzzer_sink_n_out(buzz_n), .button_pressed_out(pressed),
        .frame_ready_out(rdy));

    chain_model #(.DIGITS(4)) u_chain (
        .mclk_in(mclk_in), .chain_serial_in(sdo), .sck_in(sck), .rck_in(rck), .oe_n_in(oe_n),
        .clr_in(clr), .shift_q(shift_q), .latch_q(latch_q), .shown_out(shown),
        .rck_rise_out(rck_rise), .shifts_q(shifts));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : final_report

    // latched picture must settle on the expected frame within a bound
    task automatic wait_shown(input logic [31:0] exp);
        for (int i = 0; i < 8000 && latch_q !== exp; i++) @(posedge mclk_in);
        check(latch_q, exp);
    endtask : wait_shown

    task automatic count_on(output int cnt);
        cnt = 0;
        repeat (256) begin
            @(posedge mclk_in);
            if (oe_n === 1'b0) cnt++;
        end
    endtask : count_on

    // outputs held at their idle levels while reset stands
    task automatic reset_check;
        check({31'h0, clr}, 32'h1);
        check({31'h0, oe_n}, 32'h1);
        check({31'h0, buzz_n}, 32'h1);
        check({31'h0, sck}, 32'h0);
        check({31'h0, rck}, 32'h0);
    endtask : reset_check

    always @(posedge mclk_in) begin
        cycles++;
        // every latch must follow exactly one full frame
        if (rck_rise === 1'b1 && !srst_in) check(32'(shifts), 32'd32);
        if (cycles == 60000) begin
            n_mismatch++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        reset_check();
        check(shift_q, 32'h0);
        srst_in <= 1'b0;
        foreach (rows[i]) begin
            @(posedge mclk_in);
            temp_f <= rows[i].tf;
            time_f <= rows[i].tf;
            menu_f <= rows[i].mf;
            menu_a <= rows[i].ma;
            wait_shown(rows[i].exp);
        end
        @(posedge mclk_in);
        temp_f <= 32'h1111_1111;
        time_f <= 32'h2222_2222;
        wait_shown(32'h1111_1111);
        wait_shown(32'h2222_2222);
        bright <= 8'h00;
        repeat (4) @(posedge mclk_in);
        count_on(n);
        check(32'(n), 32'h0);
        bright <= 8'h40;
        repeat (4) @(posedge mclk_in);
        count_on(n);
        check(32'(n), 32'd64);
        bright <= 8'h00;
        menu_a <= 1'b1;
        repeat (4) @(posedge mclk_in);
        count_on(n);
        check(32'(n), 32'd256);
        menu_a <= 1'b0;
        bright <= 8'hFF;
        alarm <= 1'b1;
        repeat (4) @(posedge mclk_in);
        check({31'h0, buzz_n}, 32'h0);
        alarm <= 1'b0;
        b2 <= 1'b0;
        repeat (6) @(posedge mclk_in);
        check({31'h0, buzz_n}, 32'h1);
        check({29'h0, pressed}, 32'h2);
        b2 <= 1'b1;
        b1 <= 1'b0;
        b3 <= 1'b0;
        repeat (6) @(posedge mclk_in);
        check({29'h0, pressed}, 32'h5);
        b1 <= 1'b1;
        b3 <= 1'b1;
        repeat (6) @(posedge mclk_in);
        check({29'h0, pressed}, 32'h0);
        // rapid source changes fill the queue while the chain is busy
        full = 1'b0;
        for (int i = 1; i <= 40; i++) begin
            @(posedge mclk_in);
            temp_f <= 32'h0101_0101 * i;
            time_f <= 32'h0101_0101 * i;
            if (rdy === 1'b0) full = 1'b1;
        end
        check({31'h0, full}, 32'h1);
        wait_shown(32'h2828_2828);
        // reset in mid-run: idle levels, then a blank frame before the content returns
        srst_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        reset_check();
        srst_in <= 1'b0;
        wait_shown(32'h0);
        wait_shown(32'h2828_2828);
        final_report();
    end
endmodule : tb
